// file: verilog/iocr_pkg.sv
package iocr_pkg;

  localparam int IOCR_AW = 8;
  localparam int IOCR_DW = 8;

  // Register byte offsets.
  localparam logic [7:0] OFS_BUS_CONTROL_FIRST = 8'h00;
  localparam logic [7:0] OFS_BUS_CONTROL_SECOND = 8'h01;
  localparam logic [7:0] OFS_BUS_CONTROL_THIRD = 8'h03;
  localparam logic [7:0] OFS_OWN_BUS_ID = 8'h04;
  localparam logic [7:0] OFS_SYNC_TRANSFER_PARAMS = 8'h05;
  localparam logic [7:0] OFS_DATA_STRUCTURE_BASE = 8'h10;
  localparam logic [7:0] OFS_CHIP_TEST_FIRST = 8'h18;
  localparam logic [7:0] OFS_CHIP_TEST_THIRD = 8'h1B;
  localparam logic [7:0] OFS_CHIP_TEST_FOURTH = 8'h21;
  localparam logic [7:0] OFS_CHIP_TEST_SECOND = 8'h22;
  localparam logic [7:0] OFS_INSTRUCTION_POINTER = 8'h2C;
  localparam logic [7:0] OFS_DMA_MODE_CFG = 8'h38;
  localparam logic [7:0] OFS_DMA_IRQ_ENABLE = 8'h39;
  localparam logic [7:0] OFS_DMA_CONTROL_CFG = 8'h3B;
  localparam logic [7:0] OFS_BUS_IRQ_ENABLE_FIRST = 8'h40;
  localparam logic [7:0] OFS_BUS_IRQ_ENABLE_SECOND = 8'h41;
  localparam logic [7:0] OFS_MEMORY_ACCESS_LOCALITY = 8'h46;
  localparam logic [7:0] OFS_BUS_TIMER_FIRST = 8'h48;
  localparam logic [7:0] OFS_BUS_TIMER_SECOND = 8'h49;
  localparam logic [7:0] OFS_RESPONSE_ID_LOW = 8'h4A;
  localparam logic [7:0] OFS_RESPONSE_ID_HIGH = 8'h4B;
  localparam logic [7:0] OFS_BUS_TEST_FIRST = 8'h4D;
  localparam logic [7:0] OFS_BUS_TEST_SECOND = 8'h4E;
  localparam logic [7:0] OFS_BUS_TEST_THIRD = 8'h4F;
  localparam logic [7:0] OFS_BUS_CONTROL_FOURTH = 8'hBC;

  // Writable-bit masks; all other bits are reserved and read as zero.
  localparam logic [7:0] MSK_BUS_CONTROL_FIRST = 8'hCB;
  localparam logic [7:0] MSK_BUS_CONTROL_SECOND = 8'hA0;
  localparam logic [7:0] MSK_BUS_CONTROL_THIRD = 8'hF7;
  localparam logic [7:0] MSK_OWN_BUS_ID = 8'h6F;
  localparam logic [7:0] MSK_SYNC_TRANSFER_PARAMS = 8'hEF;
  localparam logic [7:0] MSK_CHIP_TEST_FIRST = 8'h07;
  localparam logic [7:0] MSK_CHIP_TEST_THIRD = 8'h03;
  localparam logic [7:0] MSK_CHIP_TEST_FOURTH = 8'h88;
  localparam logic [7:0] MSK_CHIP_TEST_SECOND = 8'h08;
  localparam logic [7:0] MSK_DMA_MODE_CFG = 8'hFC;
  localparam logic [7:0] MSK_DMA_IRQ_ENABLE = 8'h7D;
  localparam logic [7:0] MSK_DMA_CONTROL_CFG = 8'hB9;
  localparam logic [7:0] MSK_BUS_IRQ_ENABLE_FIRST = 8'hFF;
  localparam logic [7:0] MSK_BUS_IRQ_ENABLE_SECOND = 8'h17;
  localparam logic [7:0] MSK_MEMORY_ACCESS_LOCALITY = 8'h0F;
  localparam logic [7:0] MSK_BUS_TIMER_FIRST = 8'hFF;
  localparam logic [7:0] MSK_BUS_TIMER_SECOND = 8'h0F;
  localparam logic [7:0] MSK_FULL = 8'hFF;
  localparam logic [7:0] MSK_BUS_TEST_FIRST = 8'h8C;
  localparam logic [7:0] MSK_BUS_TEST_SECOND = 8'h22;
  localparam logic [7:0] MSK_BUS_TEST_THIRD = 8'h80;
  localparam logic [7:0] MSK_BUS_CONTROL_FOURTH = 8'h80;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;

  typedef struct packed {
    logic [1:0] arb_mode;
    logic parity_check_en;
    logic atn_on_parity_err;
    logic target_role;
    logic extra_setup_clk;
    logic no_halt_target;
    logic fast_rate_en;
    logic [2:0] sync_clk_factor;
    logic [2:0] clk_factor;
    logic resel_resp_en;
    logic sel_resp_en;
    logic wide_en;
    logic [2:0] own_id;
    logic [2:0] sync_period;
    logic [3:0] sync_offset;
    logic sync_mode;
    logic highest_speed_en;
  } iocr_bus_cfg_s;

  typedef struct packed {
    logic [1:0] burst_len;
    logic src_io;
    logic dst_io;
    logic read_line_en;
    logic read_mult_en;
    logic cache_line_en;
    logic prefetch_en;
    logic single_step;
    logic irq_pin_mode;
    logic legacy_compat;
    logic host_burst_dis;
    logic master_parity_en;
    logic fetch_pin_mode;
    logic write_inval_en;
    logic [2:0] host_bus_prio;
    logic scratch_ram_mode;
  } iocr_dma_cfg_s;

  typedef struct packed {
    logic [7:0] dma_mask;
    logic [7:0] bus_mask_first;
    logic [7:0] bus_mask_second;
  } iocr_irq_mask_s;

  typedef struct packed {
    logic [3:0] hs_timer_period;
    logic [3:0] sel_timeout;
    logic [3:0] gp_timer_period;
    logic [15:0] response_ids;
  } iocr_timer_cfg_s;

  typedef struct packed {
    logic clk_source;
    logic [1:0] clk_doubler;
    logic differential;
    logic ext_filter;
    logic active_negation;
    logic data_write_far;
    logic data_read_far;
    logic pointer_far;
    logic fetch_far;
  } iocr_phy_cfg_s;

  typedef enum logic [1:0] {
    IOCR_IDLE,
    IOCR_START
  } iocr_run_e;

endpackage : iocr_pkg

// file: verilog/iocr_regs.sv
`timescale 1ns/1ps
module iocr_regs
  import iocr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [IOCR_AW-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [IOCR_DW-1:0] reg_wdata,
  output logic [IOCR_DW-1:0] reg_rdata,
  output logic reg_hit,
  output iocr_bus_cfg_s bus_cfg,
  output iocr_dma_cfg_s dma_cfg,
  output iocr_irq_mask_s irq_mask,
  output iocr_timer_cfg_s timer_cfg,
  output iocr_phy_cfg_s phy_cfg,
  output logic [31:0] data_structure_base,
  output logic [31:0] start_address,
  output logic start_pulse,
  output logic running,
  output logic access_test_output_pin,
  input wire logic fetch_active,
  input wire logic pointer_active,
  input wire logic data_read_active,
  input wire logic data_write_active,
  input wire logic engine_halt
);

  // One-byte register space; each masked byte register is an entry here, the two 32-bit registers are not.
  logic [7:0] bytes_ff [0:255];
  logic [31:0] dsa_ff;
  logic [31:0] ip_ff;
  logic start_ff;
  logic [7:0] rdata_ff;
  logic test_pin_ff;
  iocr_run_e run_ff;

  // Offsets that map nothing get an empty mask, so writes there are lost
  // and the same decode tells the read path to return zero.
  function automatic logic [7:0] wmask(input logic [7:0] a);
    logic [7:0] m;
    m = 8'h00;
    unique case (a)
      OFS_BUS_CONTROL_FIRST: m = MSK_BUS_CONTROL_FIRST;
      OFS_BUS_CONTROL_SECOND: m = MSK_BUS_CONTROL_SECOND;
      OFS_BUS_CONTROL_THIRD: m = MSK_BUS_CONTROL_THIRD;
      OFS_OWN_BUS_ID: m = MSK_OWN_BUS_ID;
      OFS_SYNC_TRANSFER_PARAMS: m = MSK_SYNC_TRANSFER_PARAMS;
      OFS_CHIP_TEST_FIRST: m = MSK_CHIP_TEST_FIRST;
      OFS_CHIP_TEST_THIRD: m = MSK_CHIP_TEST_THIRD;
      OFS_CHIP_TEST_FOURTH: m = MSK_CHIP_TEST_FOURTH;
      OFS_CHIP_TEST_SECOND: m = MSK_CHIP_TEST_SECOND;
      OFS_DMA_MODE_CFG: m = MSK_DMA_MODE_CFG;
      OFS_DMA_IRQ_ENABLE: m = MSK_DMA_IRQ_ENABLE;
      OFS_DMA_CONTROL_CFG: m = MSK_DMA_CONTROL_CFG;
      OFS_BUS_IRQ_ENABLE_FIRST: m = MSK_BUS_IRQ_ENABLE_FIRST;
      OFS_BUS_IRQ_ENABLE_SECOND: m = MSK_BUS_IRQ_ENABLE_SECOND;
      OFS_MEMORY_ACCESS_LOCALITY: m = MSK_MEMORY_ACCESS_LOCALITY;
      OFS_BUS_TIMER_FIRST: m = MSK_BUS_TIMER_FIRST;
      OFS_BUS_TIMER_SECOND: m = MSK_BUS_TIMER_SECOND;
      OFS_RESPONSE_ID_LOW: m = MSK_FULL;
      OFS_RESPONSE_ID_HIGH: m = MSK_FULL;
      OFS_BUS_TEST_FIRST: m = MSK_BUS_TEST_FIRST;
      OFS_BUS_TEST_SECOND: m = MSK_BUS_TEST_SECOND;
      OFS_BUS_TEST_THIRD: m = MSK_BUS_TEST_THIRD;
      OFS_BUS_CONTROL_FOURTH: m = MSK_BUS_CONTROL_FOURTH;
      default: m = 8'h00;
    endcase
    return m;
  endfunction : wmask

  function automatic logic word_hit(input logic [7:0] a,
                                    input logic [7:0] base);
    return a[7:2] == base[7:2];
  endfunction : word_hit

  // Byte lane of a 32-bit register picked by the low address bits.
  function automatic logic [7:0] lane_get(input logic [31:0] w,
                                          input logic [1:0] lane);
    return w[lane*8 +: 8];
  endfunction : lane_get

  function automatic logic [31:0] lane_put(input logic [31:0] w,
                                           input logic [1:0] lane,
                                           input logic [7:0] d);
    logic [31:0] r;
    r = w;
    r[lane*8 +: 8] = d;
    return r;
  endfunction : lane_put

  logic dsa_sel;
  logic ip_sel;
  logic byte_sel;
  logic top_ptr_wr;

  assign dsa_sel = word_hit(reg_addr, OFS_DATA_STRUCTURE_BASE);
  assign ip_sel = word_hit(reg_addr, OFS_INSTRUCTION_POINTER);
  assign byte_sel = wmask(reg_addr) != 8'h00;
  assign reg_hit = dsa_sel | ip_sel | byte_sel;
  // Only the top pointer byte launches the program; the lower bytes
  // are plain stores so they can be loaded in any order before it.
  assign top_ptr_wr = reg_wr && ip_sel && (reg_addr[1:0] == 2'h3);

  // Masked bytes reset to zero and hold until rewritten.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < 256; i++)
      begin
        bytes_ff[i] <= RST_BYTE;
      end
    end
    else if (reg_wr && byte_sel)
    begin
      bytes_ff[reg_addr] <= reg_wdata & wmask(reg_addr);
    end
  end

  // The 32-bit registers are written a byte lane at a time.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dsa_ff <= RST_WORD;
    end
    else if (reg_wr && dsa_sel)
    begin
      dsa_ff <= lane_put(dsa_ff, reg_addr[1:0], reg_wdata);
    end
  end

  // The pointer is a plain store; its side effect lives in the run logic.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ip_ff <= RST_WORD;
    end
    else if (reg_wr && ip_sel)
    begin
      ip_ff <= lane_put(ip_ff, reg_addr[1:0], reg_wdata);
    end
  end

  // Execution starts on the write of the top pointer byte, so software
  // loads the low bytes first and the complete address is then seen.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      start_ff <= 1'b0;
    end
    else
    begin
      start_ff <= top_ptr_wr;
    end
  end

  // A start that meets a halt in the same cycle wins, so a fresh program
  // is never lost to the halt of the one before it.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      run_ff <= IOCR_IDLE;
    end
    else
    begin
      unique case (run_ff)
        IOCR_IDLE:
        begin
          if (start_ff)
          begin
            run_ff <= IOCR_START;
          end
        end
        IOCR_START:
        begin
          if (engine_halt && !start_ff)
          begin
            run_ff <= IOCR_IDLE;
          end
        end
        default: run_ff <= IOCR_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rdata_ff <= RST_BYTE;
    end
    else if (reg_rd)
    begin
      // The byte then stands until the next read, so a slow host may
      // take it any cycle later.
      if (dsa_sel)
      begin
        rdata_ff <= lane_get(dsa_ff, reg_addr[1:0]);
      end
      else if (ip_sel)
      begin
        rdata_ff <= lane_get(ip_ff, reg_addr[1:0]);
      end
      else if (byte_sel)
      begin
        rdata_ff <= bytes_ff[reg_addr];
      end
      else
      begin
        rdata_ff <= RST_BYTE;
      end
    end
  end

  // Test pin high the cycle after an access that is selected as far.
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      test_pin_ff <= 1'b0;
    end
    else
    begin
      test_pin_ff <= (fetch_active && phy_cfg.fetch_far)
        || (pointer_active && phy_cfg.pointer_far)
        || (data_read_active && phy_cfg.data_read_far)
        || (data_write_active && phy_cfg.data_write_far);
    end
  end

  // Short views of the stored bytes that the field decoders read.
  logic [7:0] b_c0;
  logic [7:0] b_c1;
  logic [7:0] b_c3;
  logic [7:0] b_id;
  logic [7:0] b_sx;
  logic [7:0] b_ct0;
  logic [7:0] b_ct2;
  logic [7:0] b_ct3;
  logic [7:0] b_ct4;
  logic [7:0] b_dm;
  logic [7:0] b_dc;
  logic [7:0] b_mac;
  logic [7:0] b_t0;
  logic [7:0] b_t1;
  logic [7:0] b_s1;
  logic [7:0] b_s2;
  logic [7:0] b_s3;
  logic [7:0] b_c4;

  assign b_c0 = bytes_ff[OFS_BUS_CONTROL_FIRST];
  assign b_c1 = bytes_ff[OFS_BUS_CONTROL_SECOND];
  assign b_c3 = bytes_ff[OFS_BUS_CONTROL_THIRD];
  assign b_id = bytes_ff[OFS_OWN_BUS_ID];
  assign b_sx = bytes_ff[OFS_SYNC_TRANSFER_PARAMS];
  assign b_ct0 = bytes_ff[OFS_CHIP_TEST_FIRST];
  assign b_ct2 = bytes_ff[OFS_CHIP_TEST_SECOND];
  assign b_ct3 = bytes_ff[OFS_CHIP_TEST_THIRD];
  assign b_ct4 = bytes_ff[OFS_CHIP_TEST_FOURTH];
  assign b_dm = bytes_ff[OFS_DMA_MODE_CFG];
  assign b_dc = bytes_ff[OFS_DMA_CONTROL_CFG];
  assign b_mac = bytes_ff[OFS_MEMORY_ACCESS_LOCALITY];
  assign b_t0 = bytes_ff[OFS_BUS_TIMER_FIRST];
  assign b_t1 = bytes_ff[OFS_BUS_TIMER_SECOND];
  assign b_s1 = bytes_ff[OFS_BUS_TEST_FIRST];
  assign b_s2 = bytes_ff[OFS_BUS_TEST_SECOND];
  assign b_s3 = bytes_ff[OFS_BUS_TEST_THIRD];
  assign b_c4 = bytes_ff[OFS_BUS_CONTROL_FOURTH];

  always_comb
  begin
    bus_cfg.arb_mode = b_c0[7:6];
    bus_cfg.parity_check_en = b_c0[3];
    bus_cfg.atn_on_parity_err = b_c0[1];
    bus_cfg.target_role = b_c0[0];
    bus_cfg.extra_setup_clk = b_c1[7];
    // Halt suppression is meaningful only in the target role.
    bus_cfg.no_halt_target = b_c1[5] & b_c0[0];
    bus_cfg.fast_rate_en = b_c3[7];
    bus_cfg.sync_clk_factor = b_c3[6:4];
    bus_cfg.clk_factor = b_c3[2:0];
    bus_cfg.resel_resp_en = b_id[6];
    bus_cfg.sel_resp_en = b_id[5];
    bus_cfg.wide_en = b_id[3];
    bus_cfg.own_id = b_id[2:0];
    bus_cfg.sync_period = b_sx[7:5];
    bus_cfg.sync_offset = b_sx[3:0];
    // A zero offset keeps the bus asynchronous, the reset default.
    bus_cfg.sync_mode = b_sx[3:0] != 4'h0;
    bus_cfg.highest_speed_en = b_c4[7];
  end

  // Host-side options are spread over the DMA and chip test bytes.
  always_comb
  begin
    dma_cfg.burst_len = b_dm[7:6];
    dma_cfg.src_io = b_dm[5];
    dma_cfg.dst_io = b_dm[4];
    dma_cfg.read_line_en = b_dm[3];
    dma_cfg.read_mult_en = b_dm[2];
    dma_cfg.cache_line_en = b_dc[7];
    dma_cfg.prefetch_en = b_dc[5];
    dma_cfg.single_step = b_dc[4];
    dma_cfg.irq_pin_mode = b_dc[3];
    dma_cfg.legacy_compat = b_dc[0];
    dma_cfg.host_burst_dis = b_ct4[7];
    dma_cfg.master_parity_en = b_ct4[3];
    dma_cfg.fetch_pin_mode = b_ct3[1];
    dma_cfg.write_inval_en = b_ct3[0];
    dma_cfg.host_bus_prio = b_ct0[2:0];
    dma_cfg.scratch_ram_mode = b_ct2[3];
  end

  // Masks pass through whole; their reserved positions are stored as zero.
  always_comb
  begin
    irq_mask.dma_mask = bytes_ff[OFS_DMA_IRQ_ENABLE];
    irq_mask.bus_mask_first = bytes_ff[OFS_BUS_IRQ_ENABLE_FIRST];
    irq_mask.bus_mask_second = bytes_ff[OFS_BUS_IRQ_ENABLE_SECOND];
    timer_cfg.hs_timer_period = b_t0[7:4];
    timer_cfg.sel_timeout = b_t0[3:0];
    timer_cfg.gp_timer_period = b_t1[3:0];
    timer_cfg.response_ids = {bytes_ff[OFS_RESPONSE_ID_HIGH],
                              bytes_ff[OFS_RESPONSE_ID_LOW]};
    phy_cfg.clk_source = b_s1[7];
    phy_cfg.clk_doubler = b_s1[3:2];
    phy_cfg.differential = b_s2[5];
    phy_cfg.ext_filter = b_s2[1];
    phy_cfg.active_negation = b_s3[7];
    phy_cfg.data_write_far = b_mac[3];
    phy_cfg.data_read_far = b_mac[2];
    phy_cfg.pointer_far = b_mac[1];
    phy_cfg.fetch_far = b_mac[0];
  end

  // The base is passed on as written; its use before loading is the
  // program's concern.
  assign data_structure_base = dsa_ff;
  assign start_address = ip_ff;
  assign start_pulse = start_ff;
  assign running = run_ff == IOCR_START;
  assign reg_rdata = rdata_ff;
  assign access_test_output_pin = test_pin_ff;

endmodule : iocr_regs

// file: tb/iocr_assertions.sv
`timescale 1ns/1ps
module iocr_chk
  import iocr_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [IOCR_AW-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [IOCR_DW-1:0] reg_wdata,
  input wire logic [IOCR_DW-1:0] reg_rdata,
  input wire logic reg_hit,
  input wire iocr_bus_cfg_s bus_cfg,
  input wire iocr_phy_cfg_s phy_cfg,
  input wire logic [31:0] start_address,
  input wire logic start_pulse,
  input wire logic running,
  input wire logic access_test_output_pin,
  input wire logic fetch_active,
  input wire logic pointer_active,
  input wire logic data_read_active,
  input wire logic data_write_active,
  input wire logic engine_halt
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  logic [7:0] wd_q;
  logic far_hit;
  always_ff @(posedge clock)
    wd_q <= reg_wdata;
  assign far_hit = fetch_active & phy_cfg.fetch_far
    | pointer_active & phy_cfg.pointer_far
    | data_read_active & phy_cfg.data_read_far
    | data_write_active & phy_cfg.data_write_far;

  sequence s_top_wr;
    reg_wr && reg_addr == 8'h2F;
  endsequence
  sequence s_launch;
    s_top_wr ##1 (start_pulse && !engine_halt && !reg_wr);
  endsequence

  a_start_top: assert property (s_top_wr |=> start_pulse
    && start_address[31:24] == wd_q) else $error("no start");
  a_no_spur: assert property (!(reg_wr && reg_addr == 8'h2F)
    |=> !start_pulse) else $error("stray start");
  a_run_launch: assert property (s_launch |=> running
    && !start_pulse) else $error("not running");
  a_halt_stop: assert property (engine_halt && !start_pulse
    |=> !running) else $error("halt ignored");
  a_miss_zero: assert property (reg_rd && !reg_hit
    |=> reg_rdata == 8'h00) else $error("unmapped data");
  a_rdata_hold: assert property (!reg_rd
    |=> $stable(reg_rdata)) else $error("read data moved");
  a_async_dflt: assert property (reg_wr && reg_addr == 8'h05
    && reg_wdata[3:0] == 4'h0 |=> !bus_cfg.sync_mode)
    else $error("sync without offset");
  a_role_bit: assert property (reg_wr && reg_addr == 8'h00
    |=> bus_cfg.target_role == wd_q[0]
    && bus_cfg.arb_mode == wd_q[7:6]) else $error("role field");
  a_setup_clk: assert property (reg_wr && reg_addr == 8'h01
    |=> bus_cfg.extra_setup_clk == wd_q[7]) else $error("setup bit");
  a_far_pin: assert property (access_test_output_pin
    == $past(far_hit)) else $error("locality pin");
endmodule : iocr_chk

bind iocr_regs iocr_chk u_chk (.clock, .rst_b, .reg_addr, .reg_wr,
  .reg_rd, .reg_wdata, .reg_rdata, .reg_hit, .bus_cfg, .phy_cfg,
  .start_address, .start_pulse, .running, .access_test_output_pin,
  .fetch_active, .pointer_active, .data_read_active,
  .data_write_active, .engine_halt);

// file: tb/iocr_engine.sv
`timescale 1ns/1ps
module iocr_engine (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic running,
  input wire logic halt_req,
  output logic fetch_active,
  output logic pointer_active,
  output logic data_read_active,
  output logic data_write_active,
  output logic engine_halt
);
  logic [1:0] phase_ff;
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
      phase_ff <= 2'h0;
    else if (running)
      phase_ff <= phase_ff + 2'h1;
  // One access kind a cycle, so all four locality bits can be exercised; the test sets only the fetch bit.
  assign fetch_active = running && phase_ff == 2'h0;
  assign pointer_active = running && phase_ff == 2'h1;
  assign data_read_active = running && phase_ff == 2'h2;
  assign data_write_active = running && phase_ff == 2'h3;
  assign engine_halt = halt_req && running;
endmodule : iocr_engine

// file: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import iocr_pkg::*;
  localparam logic [15:0] TBL [30] = '{16'h00CB, 16'h01A0, 16'h03F7,
    16'h046F, 16'h05EF, 16'h10FF, 16'h11FF, 16'h12FF, 16'h13FF,
    16'h1807, 16'h1B03, 16'h2188, 16'h2208, 16'h2CFF, 16'h2DFF,
    16'h2EFF, 16'h38FC, 16'h397D, 16'h3BB9, 16'h40FF, 16'h4117,
    16'h460F, 16'h48FF, 16'h490F, 16'h4AFF, 16'h4BFF, 16'h4D8C,
    16'h4E22, 16'h4F80, 16'hBC80};
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic halt_req = 1'b0;
  logic rd_seen = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [7:0] v [30];
  logic [7:0] exp_q [$];
  logic reg_hit, start_pulse, running, pin, fa, pa, ra, wa, halt;
  logic [31:0] dsb, start_address;
  iocr_bus_cfg_s bus_cfg;
  iocr_dma_cfg_s dma_cfg;
  iocr_irq_mask_s irq_mask;
  iocr_timer_cfg_s timer_cfg;
  iocr_phy_cfg_s phy_cfg;
  int fail_count = 0;
  int n_checks = 0;

  always #50 clock = ~clock;

  iocr_regs dut (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .bus_cfg(bus_cfg),
    .dma_cfg(dma_cfg), .irq_mask(irq_mask), .timer_cfg(timer_cfg),
    .phy_cfg(phy_cfg), .data_structure_base(dsb),
    .start_address(start_address), .start_pulse(start_pulse),
    .running(running), .access_test_output_pin(pin),
    .fetch_active(fa), .pointer_active(pa), .data_read_active(ra),
    .data_write_active(wa), .engine_halt(halt));
  iocr_engine u_eng (.clock(clock), .rst_b(rst_b), .running(running),
    .halt_req(halt_req), .fetch_active(fa), .pointer_active(pa),
    .data_read_active(ra), .data_write_active(wa), .engine_halt(halt));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
    exp_q.push_back(e);
  endtask : rd

  task automatic idle(input int n);
    repeat (n)
    begin
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
    end
  endtask : idle

  // Back-to-back reads of the whole map but the top pointer byte, zero or last written data.
  task automatic scan(input logic zero);
    for (int i = 0; i < 30; i++)
      rd(TBL[i][15:8], zero ? 8'h00 : v[i] & TBL[i][7:0]);
    idle(2);
  endtask : scan

  task automatic summarize;
    $display("checks %0d failures %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : summarize

  always @(posedge clock)
    rd_seen <= reg_rd;
  always @(negedge clock)
    if (rd_seen)
      chk({24'h0, reg_rdata}, {24'h0, exp_q.pop_front()});

  initial
  begin
    iocr_bus_cfg_s eb;
    int seed;
    seed = $urandom(32'h6ACE);
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    scan(1'b1);
    for (int i = 0; i < 30; i++)
    begin
      v[i] = 8'($urandom) & TBL[i][7:0];
      wr(TBL[i][15:8], v[i]);
    end
    wr(8'h02, 8'hFF);
    rd(8'h02, 8'h00);
    idle(1);
    @(negedge clock);
    chk({31'h0, reg_hit}, 32'h0);
    chk({13'h0, dma_cfg}, {13'h0, v[16][7:2], v[18][7], v[18][5:3],
      v[18][0], v[11][7], v[11][3], v[10][1:0], v[9][2:0],
      v[12][3]});
    chk({8'h0, irq_mask}, {8'h0, v[17], v[19], v[20]});
    chk({4'h0, timer_cfg},
      {4'h0, v[22], v[23][3:0], v[25], v[24]});
    chk({22'h0, phy_cfg}, {22'h0, v[26][7], v[26][3:2], v[27][5],
      v[27][1], v[28][7], v[21][3:0]});
    chk({31'h0, bus_cfg.highest_speed_en}, {31'h0, v[29][7]});
    chk(dsb, {v[8], v[7], v[6], v[5]});
    chk({6'h0, start_address[23:0], running, start_pulse},
      {6'h0, v[15], v[14], v[13], 2'h0});
    scan(1'b0);
    @(posedge clock);
    rst_b <= 1'b0;
    idle(2);
    rst_b <= 1'b1;
    scan(1'b1);
    wr(8'h00, 8'hC9);
    wr(8'h01, 8'hA0);
    wr(8'h03, 8'hB5);
    wr(8'h04, 8'h6D);
    wr(8'h05, 8'hA0);
    wr(8'h39, 8'h7D);
    wr(8'h48, 8'hA5);
    idle(1);
    @(negedge clock);
    eb = '{2'h3, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 3'h3, 3'h5,
      1'b1, 1'b1, 1'b1, 3'h5, 3'h5, 4'h0, 1'b0, 1'b0};
    chk({3'h0, bus_cfg}, {3'h0, eb});
    chk({16'h0, irq_mask.dma_mask, timer_cfg.hs_timer_period,
      timer_cfg.sel_timeout}, 32'h7DA5);
    wr(8'h05, 8'hA3);
    idle(1);
    @(negedge clock);
    chk({30'h0, bus_cfg.sync_mode, 1'b1}, 32'h3);
    wr(8'h10, 8'hEF);
    wr(8'h11, 8'hBE);
    wr(8'h12, 8'hAD);
    wr(8'h13, 8'hDE);
    wr(8'h46, 8'h01);
    wr(8'h2C, 8'h78);
    wr(8'h2D, 8'h56);
    wr(8'h2E, 8'h34);
    wr(8'h2F, 8'h12);
    idle(1);
    @(negedge clock);
    chk(dsb, 32'hDEADBEEF);
    chk(start_address, 32'h12345678);
    chk({31'h0, start_pulse}, 32'h1);
    @(negedge clock);
    chk({30'h0, running, start_pulse}, 32'h2);
    seed = 0;
    repeat (8)
    begin
      @(negedge clock);
      seed += int'(pin);
    end
    chk(32'(seed), 32'h2);
    @(posedge clock);
    halt_req <= 1'b1;
    @(posedge clock);
    halt_req <= 1'b0;
    @(negedge clock);
    chk({31'h0, running}, 32'h0);
    wr(8'h2F, 8'h9A);
    idle(3);
    rst_b <= 1'b0;
    @(negedge clock);
    chk(start_address, 32'h0);
    chk({31'h0, running}, 32'h0);
    @(posedge clock);
    rst_b <= 1'b1;
    idle(2);
    summarize();
  end
endmodule : tb_top
